// file: include/plm_pkg.sv
// Shared constants and carriers for the process loop mode control block.
// Assumes one 50 MHz clock; software reaches the registers over APB.
package plm_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned MODE_DELAY_MS = 3000;
  localparam int unsigned MODE_DELAY_CYC = (CLK_HZ / 1000) * MODE_DELAY_MS;
  localparam int unsigned LINE_GROUP = 3;
  localparam int unsigned HZ_50 = 50;
  localparam int unsigned HZ_60 = 60;
  localparam logic [7:0] PWR_FULL = 8'h64;
  localparam logic [7:0] BUMP_BAND = 8'h05;
  localparam logic [7:0] BUMP_LIMIT = 8'h4b;
  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SETPT = 8'h04;
  localparam logic [7:0] A_MANPWR = 8'h08;
  localparam logic [7:0] A_HEAT = 8'h0c;
  localparam logic [7:0] A_COOL = 8'h10;
  localparam logic [7:0] A_TINT = 8'h14;
  localparam logic [7:0] A_DBAND = 8'h18;
  localparam logic [7:0] A_RANGE = 8'h1c;
  localparam logic [7:0] A_PRESET = 8'h20;
  localparam logic [7:0] A_ALM0 = 8'h24;
  localparam logic [7:0] A_STAT = 8'h30;
  localparam logic [7:0] A_PV = 8'h34;
  // Control register fields
  localparam int unsigned F_OUTFN = 0;
  localparam int unsigned F_MODE = 6;
  localparam int unsigned F_FAIL = 7;
  localparam int unsigned F_LATCH = 9;
  localparam int unsigned F_LINE = 10;
  localparam int unsigned F_HALG = 11;
  localparam int unsigned F_CALG = 12;
  localparam int unsigned F_CONF = 13;
  localparam int unsigned F_ERRCLR = 14;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  typedef enum logic [1:0] {
    PLM_FN_OFF = 2'b00,
    PLM_FN_HEAT = 2'b01,
    PLM_FN_COOL = 2'b10,
    PLM_FN_ALARM = 2'b11
  } plm_fn_t;
  typedef enum logic [1:0] {
    PLM_FAIL_BUMPLESS = 2'b00,
    PLM_FAIL_PRESET = 2'b01,
    PLM_FAIL_OFF = 2'b10
  } plm_fail_t;
  typedef struct packed {
    logic signed [15:0] pband;
    logic [15:0] hyst;
  } plm_loop_t;
  typedef struct packed {
    logic signed [15:0] high;
    logic signed [15:0] low;
  } plm_alarm_t;
endpackage : plm_pkg

// file: logic/plm_top.sv
// Process loop mode control: auto/manual, input failure, on-off and PID, time base.
// Assumes pv_raw, pv_valid, line_zc and keys synchronous to ref_clk; APB slave.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
module plm_top #(
  parameter int unsigned MODE_DELAY = plm_pkg::MODE_DELAY_CYC,
  parameter int unsigned TICK_DIV = 50000
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] pv_raw,
  input wire logic pv_valid,
  input wire logic line_zc,
  input wire logic key_confirm,
  output logic [2:0] out_drive,
  output logic manual_led,
  output logic input_err
);
  localparam logic [15:0] RAW_SPAN = 16'h0fff;

  logic [31:0] ctrl_q;
  logic signed [15:0] setpt_q, auto_sp_q;
  logic [7:0] manpwr_q, last_man_q, preset_q;
  plm_pkg::plm_loop_t heat_q, cool_q;
  logic [15:0] tint_q;
  logic signed [15:0] dband_q;
  logic signed [15:0] rlo_q, rhi_q;
  plm_pkg::plm_alarm_t alm_q [3];
  logic mode_man_q, mode_pend_q, fail_man_q, err_q;
  logic [31:0] mode_cnt_q;
  logic signed [15:0] pv_q, pv_prev_q;
  logic signed [23:0] integ_q;
  logic [7:0] heat_pwr_q, cool_pwr_q, last_auto_q, ref_pwr_q;
  logic [15:0] stable_cnt_q;
  logic stable_q;
  logic heat_on_q, cool_on_q;
  logic [1:0] zc_cnt_q;
  logic zc_prev_q;
  logic [9:0] acc_h_q, acc_c_q;
  logic burst_h_q, burst_c_q;
  logic [31:0] tick_cnt_q;
  logic [7:0] line_cyc_q;
  logic [2:0] out_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic manual_q;

  function automatic logic [7:0] clamp_pct(input logic signed [23:0] v);
    if (v < 24'sd0) return 8'h00;
    if (v > 24'sd100) return plm_pkg::PWR_FULL;
    return v[7:0];
  endfunction : clamp_pct

  function automatic logic signed [15:0] sabs(input logic signed [15:0] v);
    return (v < 16'sd0) ? -v : v;
  endfunction : sabs

  wire plm_pkg::plm_fail_t fail_sel = plm_pkg::plm_fail_t'(ctrl_q[plm_pkg::F_FAIL +: 2]);
  wire latch_en = ctrl_q[plm_pkg::F_LATCH];
  wire line60 = ctrl_q[plm_pkg::F_LINE];
  wire heat_onoff = ctrl_q[plm_pkg::F_HALG];
  wire cool_onoff = ctrl_q[plm_pkg::F_CALG];
  wire mode_req = ctrl_q[plm_pkg::F_MODE];

  // Range scaling, raw code 0..4095 maps onto rlo..rhi
  wire signed [31:0] span = 32'(rhi_q) - 32'(rlo_q);
  wire signed [31:0] scaled = 32'(rlo_q) + (span * $signed({20'h0, pv_raw})) / 32'sd4095;
  wire signed [15:0] pv_now = scaled[15:0];

  wire signed [15:0] err_v = setpt_q - pv_q;
  wire below = err_v > 16'sd0;
  // Dead band shifts the band edges apart or, when negative, overlaps them
  wire signed [15:0] half_db = dband_q >>> 1;
  wire signed [15:0] heat_err = err_v - half_db;
  wire signed [15:0] cool_err = -err_v - half_db;
  wire in_dead = (dband_q > 16'sd0) && (sabs(err_v) <= half_db);
  wire signed [15:0] band = below ? heat_q.pband : cool_q.pband;
  wire in_band = sabs(err_v) < band;
  wire in_deriv = sabs(err_v) < (band <<< 1);
  wire signed [15:0] dpv = pv_q - pv_prev_q;
  wire signed [23:0] d_term = in_deriv ? -24'(dpv) * 24'sd4 : 24'sd0;
  wire signed [23:0] i_term = integ_q >>> 8;
  wire signed [15:0] hband = (heat_q.pband == 16'sd0) ? 16'sd1 : heat_q.pband;
  wire signed [15:0] cband = (cool_q.pband == 16'sd0) ? 16'sd1 : cool_q.pband;
  wire signed [23:0] p_heat = in_dead ? 24'sd0 : (24'(heat_err) * 24'sd100) / 24'(hband);
  wire signed [23:0] p_cool = in_dead ? 24'sd0 : (24'(cool_err) * 24'sd100) / 24'(cband);
  wire [7:0] heat_calc = clamp_pct(p_heat + i_term + d_term);
  wire [7:0] cool_calc = clamp_pct(p_cool - i_term - d_term);

  wire run_closed = !mode_man_q && !fail_man_q && !err_q;
  wire closed_man = fail_man_q || mode_man_q;
  wire [7:0] open_pwr = mode_man_q ? manpwr_q : last_auto_q;
  wire [7:0] fail_pwr = (fail_sel == plm_pkg::PLM_FAIL_PRESET) ? preset_q : 8'h00;
  wire [7:0] heat_dem = closed_man ? open_pwr : (err_q ? fail_pwr : heat_pwr_q);
  wire [7:0] cool_dem = closed_man ? open_pwr : (err_q ? fail_pwr : cool_pwr_q);

  wire zc_rise = line_zc && !zc_prev_q;
  wire group_end = zc_rise && (zc_cnt_q == 2'(plm_pkg::LINE_GROUP - 1));
  wire tick = (tick_cnt_q == TICK_DIV - 1);
  // Line cycles within one second of mains, readable in status
  wire [7:0] line_hz = line60 ? 8'(plm_pkg::HZ_60) : 8'(plm_pkg::HZ_50);

  wire apb_wr = psel && penable && pwrite;
  wire apb_rd = psel && !penable && !pwrite;
  wire hit = (paddr <= plm_pkg::A_ALM0 + 8'h08) || (paddr == plm_pkg::A_STAT)
    || (paddr == plm_pkg::A_PV);
  wire [1:0] alm_idx = 2'((paddr - plm_pkg::A_ALM0) >> 2);
  wire is_alm = (paddr >= plm_pkg::A_ALM0) && (paddr < plm_pkg::A_ALM0 + 8'h0c);
  wire [31:0] rd_mux =
    (paddr == plm_pkg::A_CTRL) ? ctrl_q :
    (paddr == plm_pkg::A_SETPT) ? {16'h0, setpt_q} :
    (paddr == plm_pkg::A_MANPWR) ? {24'h0, manpwr_q} :
    (paddr == plm_pkg::A_HEAT) ? heat_q :
    (paddr == plm_pkg::A_COOL) ? cool_q :
    (paddr == plm_pkg::A_TINT) ? {16'h0, tint_q} :
    (paddr == plm_pkg::A_DBAND) ? {16'h0, dband_q} :
    (paddr == plm_pkg::A_RANGE) ? {rhi_q, rlo_q} :
    (paddr == plm_pkg::A_PRESET) ? {24'h0, preset_q} :
    is_alm ? alm_q[alm_idx] :
    (paddr == plm_pkg::A_STAT) ? {heat_pwr_q, cool_pwr_q, line_cyc_q, stable_q, fail_man_q,
      mode_pend_q, mode_man_q, err_q, out_q} :
    (paddr == plm_pkg::A_PV) ? {16'h0, pv_q} : 32'h00000000;

  wire w_ctrl = apb_wr && paddr == plm_pkg::A_CTRL;
  wire w_sp = apb_wr && paddr == plm_pkg::A_SETPT;
  wire w_man = apb_wr && paddr == plm_pkg::A_MANPWR;
  wire mode_change = w_ctrl && (pwdata[plm_pkg::F_MODE] != mode_req);
  wire confirm = key_confirm || (w_ctrl && pwdata[plm_pkg::F_CONF]);
  wire mode_fire = mode_pend_q && (confirm || mode_cnt_q >= MODE_DELAY - 1);

  // APB slave, one wait-free access; unmapped addresses above the alarm registers answer pslverr
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !hit;
      if (apb_rd)
        prdata_q <= hit ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      ctrl_q <= plm_pkg::CTRL_RST;
      setpt_q <= 16'sh0000;
      auto_sp_q <= 16'sh0000;
      manpwr_q <= 8'h00;
      last_man_q <= 8'h00;
      preset_q <= 8'h00;
      heat_q <= '0;
      cool_q <= '0;
      tint_q <= 16'h0001;
      dband_q <= 16'sh0000;
      rlo_q <= 16'sh0000;
      rhi_q <= 16'sh0fff;
      for (int i = 0; i < 3; i++) alm_q[i] <= '0;
    end
    else
    begin
      if (apb_wr && pready_q)
      begin
        // Error clear and confirm are self-clearing command bits
        if (w_ctrl) ctrl_q <= pwdata & ~(32'h1 << plm_pkg::F_CONF)
          & ~(32'h1 << plm_pkg::F_ERRCLR);
        if (w_sp) setpt_q <= pwdata[15:0];
        if (w_man) manpwr_q <= (pwdata[7:0] > plm_pkg::PWR_FULL) ? plm_pkg::PWR_FULL
          : pwdata[7:0];
        if (paddr == plm_pkg::A_HEAT) heat_q <= pwdata;
        if (paddr == plm_pkg::A_COOL) cool_q <= pwdata;
        if (paddr == plm_pkg::A_TINT) tint_q <= pwdata[15:0];
        if (paddr == plm_pkg::A_DBAND) dband_q <= pwdata[15:0];
        if (paddr == plm_pkg::A_RANGE) {rhi_q, rlo_q} <= pwdata;
        if (paddr == plm_pkg::A_PRESET) preset_q <= pwdata[7:0];
        if (is_alm) alm_q[alm_idx] <= pwdata;
      end
      // Restore stands last so a confirm write cannot swallow it
      if (mode_fire)
      begin
        if (mode_req) manpwr_q <= last_man_q;
        else setpt_q <= auto_sp_q;
      end
      else if (mode_man_q)
        last_man_q <= manpwr_q;
      else
        auto_sp_q <= setpt_q;
    end
  end

  // Mode selection with settle delay
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      mode_man_q <= 1'b0;
      mode_pend_q <= 1'b0;
      mode_cnt_q <= 32'h00000000;
    end
    else if (mode_change)
    begin
      mode_pend_q <= 1'b1;
      mode_cnt_q <= 32'h00000000;
    end
    else if (mode_fire)
    begin
      mode_man_q <= mode_req;
      mode_pend_q <= 1'b0;
    end
    else if (mode_pend_q)
      mode_cnt_q <= mode_cnt_q + 32'h1;
  end

  // Input error and failure response
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      err_q <= 1'b0;
      fail_man_q <= 1'b0;
    end
    else if (!pv_valid)
    begin
      err_q <= 1'b1;
      if (!err_q && !mode_man_q && fail_sel == plm_pkg::PLM_FAIL_BUMPLESS && stable_q
        && last_auto_q < plm_pkg::BUMP_LIMIT)
        fail_man_q <= 1'b1;
    end
    else if (err_q && (!latch_en || (w_ctrl && pwdata[plm_pkg::F_ERRCLR])))
    begin
      err_q <= 1'b0;
      fail_man_q <= 1'b0;
    end
  end

  // Sampling, PID state and power stability tracking on the controller tick
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      tick_cnt_q <= 32'h00000000;
      pv_q <= 16'sh0000;
      pv_prev_q <= 16'sh0000;
      integ_q <= 24'sh000000;
      heat_pwr_q <= 8'h00;
      cool_pwr_q <= 8'h00;
      last_auto_q <= 8'h00;
      ref_pwr_q <= 8'h00;
      stable_cnt_q <= 16'h0000;
      stable_q <= 1'b0;
      heat_on_q <= 1'b0;
      cool_on_q <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick ? 32'h00000000 : tick_cnt_q + 32'h1;
      if (tick && pv_valid)
      begin
        pv_prev_q <= pv_q;
        pv_q <= pv_now;
      end
      if (tick && run_closed)
      begin
        if (!in_band) integ_q <= 24'sh000000;
        else integ_q <= integ_q + 24'(err_v);
        heat_pwr_q <= heat_onoff ? (heat_on_q ? plm_pkg::PWR_FULL : 8'h00) : heat_calc;
        cool_pwr_q <= cool_onoff ? (cool_on_q ? plm_pkg::PWR_FULL : 8'h00) : cool_calc;
        last_auto_q <= heat_calc;
        if (heat_calc > ref_pwr_q + plm_pkg::BUMP_BAND
          || heat_calc + plm_pkg::BUMP_BAND < ref_pwr_q)
        begin
          ref_pwr_q <= heat_calc;
          stable_cnt_q <= 16'h0000;
          stable_q <= 1'b0;
        end
        else if (stable_cnt_q >= tint_q)
          stable_q <= 1'b1;
        else
          stable_cnt_q <= stable_cnt_q + 16'h1;
      end
      // Hysteresis: on at deviation by hyst, off once set point reached
      if (err_v >= $signed(heat_q.hyst)) heat_on_q <= 1'b1;
      else if (err_v <= 16'sd0) heat_on_q <= 1'b0;
      if (-err_v >= $signed(cool_q.hyst)) cool_on_q <= 1'b1;
      else if (err_v >= 16'sd0) cool_on_q <= 1'b0;
    end
  end

  // Three-line-cycle burst decisions with error-diffusion accumulators
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      zc_prev_q <= 1'b0;
      zc_cnt_q <= 2'b00;
      acc_h_q <= 10'h000;
      acc_c_q <= 10'h000;
      burst_h_q <= 1'b0;
      burst_c_q <= 1'b0;
      line_cyc_q <= 8'h00;
    end
    else
    begin
      zc_prev_q <= line_zc;
      if (zc_rise) zc_cnt_q <= (zc_cnt_q == 2'(plm_pkg::LINE_GROUP - 1)) ? 2'b00 : zc_cnt_q + 2'b01;
      if (zc_rise) line_cyc_q <= (line_cyc_q >= line_hz - 8'h01) ? 8'h00 : line_cyc_q + 8'h01;
      if (group_end)
      begin
        burst_h_q <= (acc_h_q + 10'(heat_dem)) >= 10'(plm_pkg::PWR_FULL);
        acc_h_q <= ((acc_h_q + 10'(heat_dem)) >= 10'(plm_pkg::PWR_FULL))
          ? acc_h_q + 10'(heat_dem) - 10'(plm_pkg::PWR_FULL) : acc_h_q + 10'(heat_dem);
        burst_c_q <= (acc_c_q + 10'(cool_dem)) >= 10'(plm_pkg::PWR_FULL);
        acc_c_q <= ((acc_c_q + 10'(cool_dem)) >= 10'(plm_pkg::PWR_FULL))
          ? acc_c_q + 10'(cool_dem) - 10'(plm_pkg::PWR_FULL) : acc_c_q + 10'(cool_dem);
      end
    end
  end

  // Per-output function select and alarm comparison
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      out_q <= 3'b000;
    else
      for (int i = 0; i < 3; i++)
        case (plm_pkg::plm_fn_t'(ctrl_q[plm_pkg::F_OUTFN + 2*i +: 2]))
          plm_pkg::PLM_FN_HEAT:
            out_q[i] <= (err_q && !closed_man && heat_onoff) ? 1'b0 : burst_h_q;
          plm_pkg::PLM_FN_COOL:
            out_q[i] <= (err_q && !closed_man && cool_onoff) ? 1'b0 : burst_c_q;
          plm_pkg::PLM_FN_ALARM:
            out_q[i] <= (pv_q > alm_q[i].high) || (pv_q < alm_q[i].low);
          default:
            out_q[i] <= 1'b0;
        endcase
  end

  // Indicator registered so the pin never glitches between mode flops
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      manual_q <= 1'b0;
    else
      manual_q <= closed_man;
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign out_drive = out_q;
  assign manual_led = manual_q;
  assign input_err = err_q;
endmodule : plm_top

// file: verif/plm_top_sva.sv
// Checker for plm_top ports: bus answer timing, reset state, input error flag.
// Assumes one clock domain; bound into every plm_top instance.
`timescale 1ns/1ns
module plm_top_sva (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pv_valid,
  input wire logic [2:0] out_drive,
  input wire logic manual_led,
  input wire logic input_err
);
  chk_ready_setup: assert property (@(posedge ref_clk) disable iff (!rst_b)
    psel && !penable |=> pready) else $error("no pready after setup");
  chk_ready_single: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pready |=> !pready) else $error("pready longer than one cycle");
  chk_ready_access: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pready |-> psel && penable) else $error("pready outside access phase");
  chk_slverr_ready: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pslverr |-> pready) else $error("pslverr without pready");
  chk_slverr_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
  // Reset edge must leave every load off and no flags up
  chk_reset_quiet: assert property (@(posedge ref_clk)
    !rst_b |=> out_drive == 3'h0 && !input_err && !manual_led) else $error("outputs live in reset");
  chk_err_on_loss: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !pv_valid [*4] |-> input_err) else $error("input error not flagged");
  chk_err_cause: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(input_err) |-> !$past(pv_valid) || !$past(pv_valid, 2))
    else $error("input error raised with good sensor");
endmodule : plm_top_sva

bind plm_top plm_top_sva chk_u (
  .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pv_valid(pv_valid),
  .out_drive(out_drive), .manual_led(manual_led), .input_err(input_err)
);

// file: verif/plm_sensor_model.sv
// Sensor and mains model: process code, sensor health, zero-cross square wave.
// Assumes the bench sets code and health; one mains cycle is ZC_CYC clocks.
`timescale 1ns/1ns
module plm_sensor_model #(
  parameter int ZC_CYC = 10
) (
  input wire logic ref_clk,
  input wire logic [11:0] code_in,
  input wire logic good_in,
  output logic [11:0] pv_raw,
  output logic pv_valid,
  output logic line_zc
);
  int cnt = 0;
  initial
  begin
    pv_raw = 12'h000;
    pv_valid = 1'b1;
  end
  // A dead sensor gives changing noise, never its last reading
  always @(posedge ref_clk)
  begin
    cnt <= (cnt == ZC_CYC - 1) ? 0 : cnt + 1;
    pv_valid <= good_in;
    pv_raw <= good_in ? code_in : ~pv_raw ^ cnt[11:0];
  end
  assign line_zc = (cnt < ZC_CYC / 2);
endmodule : plm_sensor_model

// file: verif/plm_top_tb.sv
// Self-checking bench for plm_top: registers, on-off, PID failure, manual mode.
// Assumes plm_sensor_model feeds the sensor and mains pins; short mode delay.
`timescale 1ns/1ns
module plm_top_tb;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic key_confirm = 1'b0;
  logic [11:0] code = 12'h000;
  logic good = 1'b1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] pv_raw;
  logic pv_valid;
  logic line_zc;
  logic [2:0] out_drive;
  logic manual_led;
  logic input_err;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;

  always #10 ref_clk = ~ref_clk;

  plm_top #(.MODE_DELAY(50), .TICK_DIV(8)) dut_u (
    .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pv_raw(pv_raw), .pv_valid(pv_valid), .line_zc(line_zc), .key_confirm(key_confirm),
    .out_drive(out_drive), .manual_led(manual_led), .input_err(input_err)
  );
  plm_sensor_model #(.ZC_CYC(10)) sensor_u (
    .ref_clk(ref_clk), .code_in(code), .good_in(good), .pv_raw(pv_raw),
    .pv_valid(pv_valid), .line_zc(line_zc)
  );

  task automatic report_and_stop();
    if (bad_count == 0 && compares > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Request held until pready is sampled high; no wait count assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
    begin
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One extra mains cycle lets the registered burst decision land
  task automatic grp(input int n);
    repeat (3 * n + 1) @(posedge line_zc);
    @(negedge ref_clk);
  endtask : grp

  task automatic t_regs();
    apb(1'b0, plm_pkg::A_CTRL, 32'h0);
    check("ctrl reset", rd, plm_pkg::CTRL_RST);
    apb(1'b0, 8'h3c, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, plm_pkg::A_SETPT, 32'h0000_0258);
    apb(1'b1, plm_pkg::A_RANGE, 32'h044c_0064);
    apb(1'b1, plm_pkg::A_HEAT, 32'h000a_0000);
    apb(1'b1, plm_pkg::A_COOL, 32'h000a_0000);
    apb(1'b1, plm_pkg::A_TINT, 32'h0000_0004);
    apb(1'b1, plm_pkg::A_PRESET, 32'h0000_0064);
    apb(1'b0, plm_pkg::A_SETPT, 32'h0);
    check("setpoint", rd, 32'h0000_0258);
    grp(1);
    apb(1'b0, plm_pkg::A_PV, 32'h0);
    check("pv low end", rd, 32'h0000_0064);
    code <= 12'hfff;
    grp(1);
    apb(1'b0, plm_pkg::A_PV, 32'h0);
    check("pv high end", rd, 32'h0000_044c);
  endtask : t_regs

  task automatic t_onoff();
    apb(1'b1, plm_pkg::A_CTRL, 32'h0000_1889);
    grp(2);
    check("cool on above", {29'h0, out_drive}, 32'h2);
    code <= 12'h000;
    grp(2);
    check("heat on below", {29'h0, out_drive}, 32'h1);
    good <= 1'b0;
    grp(2);
    check("onoff err", {31'h0, input_err}, 32'h1);
    check("onoff fail off", {29'h0, out_drive}, 32'h0);
    good <= 1'b1;
    code <= 12'hfff;
    grp(2);
    check("err self clear", {31'h0, input_err}, 32'h0);
    apb(1'b1, plm_pkg::A_CTRL, 32'h0000_182a);
    grp(2);
    check("all cool", {29'h0, out_drive}, 32'h7);
    apb(1'b1, plm_pkg::A_ALM0 + 8'h08, 32'h03e8_0000);
    apb(1'b1, plm_pkg::A_CTRL, 32'h0000_183a);
    grp(1);
    check("alarm high", {29'h0, out_drive}, 32'h7);
    apb(1'b1, plm_pkg::A_ALM0 + 8'h08, 32'h0800_0000);
    repeat (3) @(negedge ref_clk);
    check("alarm clear", {29'h0, out_drive}, 32'h3);
  endtask : t_onoff

  task automatic t_fail();
    apb(1'b1, plm_pkg::A_CTRL, 32'h0000_0081);
    code <= 12'h000;
    grp(2);
    apb(1'b0, plm_pkg::A_STAT, 32'h0);
    check("pid clamp", {24'h0, rd[31:24]}, 32'h64);
    check("no cool below", {24'h0, rd[23:16]}, 32'h0);
    code <= 12'hfff;
    grp(2);
    check("heat off above", {29'h0, out_drive}, 32'h0);
    good <= 1'b0;
    grp(2);
    check("preset on", {29'h0, out_drive}, 32'h1);
    apb(1'b1, plm_pkg::A_CTRL, 32'h0000_0101);
    grp(2);
    check("fail off", {29'h0, out_drive}, 32'h0);
    good <= 1'b1;
    grp(2);
    apb(1'b1, plm_pkg::A_CTRL, 32'h0000_0001);
    grp(2);
    good <= 1'b0;
    grp(1);
    check("bumpless manual", {31'h0, manual_led}, 32'h1);
    good <= 1'b1;
    grp(1);
    check("resume auto", {31'h0, manual_led}, 32'h0);
  endtask : t_fail

  task automatic t_manual();
    int on;
    on = 0;
    apb(1'b1, plm_pkg::A_CTRL, 32'h0000_0041);
    repeat (20) @(negedge ref_clk);
    check("mode pending", {31'h0, manual_led}, 32'h0);
    repeat (40) @(negedge ref_clk);
    check("mode applied", {31'h0, manual_led}, 32'h1);
    apb(1'b1, plm_pkg::A_MANPWR, 32'h0000_0064);
    grp(2);
    check("manual full", {29'h0, out_drive}, 32'h1);
    apb(1'b1, plm_pkg::A_MANPWR, 32'h0000_0000);
    grp(2);
    check("manual zero", {29'h0, out_drive}, 32'h0);
    apb(1'b1, plm_pkg::A_MANPWR, 32'h0000_0032);
    for (int i = 0; i < 8; i++)
    begin
      grp(0);
      if (out_drive[0] === 1'b1)
      begin
        on++;
      end
    end
    check("half bursts", {31'h0, on > 0 && on < 8}, 32'h1);
    apb(1'b1, plm_pkg::A_SETPT, 32'h0000_0100);
    apb(1'b1, plm_pkg::A_CTRL, 32'h0000_0001);
    key_confirm <= 1'b1;
    @(posedge ref_clk);
    key_confirm <= 1'b0;
    repeat (3) @(negedge ref_clk);
    check("confirm key", {31'h0, manual_led}, 32'h0);
    apb(1'b0, plm_pkg::A_SETPT, 32'h0);
    check("setpoint restored", rd, 32'h0000_0258);
    apb(1'b1, plm_pkg::A_MANPWR, 32'h0000_0010);
    apb(1'b1, plm_pkg::A_CTRL, 32'h0000_0041);
    apb(1'b1, plm_pkg::A_CTRL, 32'h0000_2041);
    repeat (3) @(negedge ref_clk);
    check("confirm bit", {31'h0, manual_led}, 32'h1);
    apb(1'b0, plm_pkg::A_MANPWR, 32'h0);
    check("power restored", rd, 32'h0000_0032);
  endtask : t_manual

  // Whole run is under 1500 cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs();
    t_onoff();
    t_fail();
    t_manual();
    report_and_stop();
  end
endmodule : plm_top_tb
